// *** rtl/pmcc_params.svh ***
// Purpose: constants for the power mode and clock controller
// Assumes: 250 MHz core clock
// Notes:   counts derive from the printed times and rates
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH
`define PMCC_CLK_MHZ            250
`define PMCC_MAIN_CLOCK_MHZ     48
`define PMCC_MEDIUM_CLOCK_MHZ   2
`define PMCC_SLOW_CLOCK_HZ      32768
// slow clock emulated by a divider of the core clock: half period in cycles
`define PMCC_SLOW_HALF_CYCLES   ((`PMCC_CLK_MHZ * 1000000) / (2 * `PMCC_SLOW_CLOCK_HZ))
`define PMCC_MEDIUM_HALF_CYCLES ((`PMCC_CLK_MHZ) / (2 * `PMCC_MEDIUM_CLOCK_MHZ))
`define PMCC_PIN_COUNT          8
`define PMCC_CAUSE_POR          2'h0
`define PMCC_CAUSE_PIN_RESET    2'h1
`define PMCC_CAUSE_WAKE_PIN     2'h2
`define PMCC_SLOW_SRC_RC        2'h0
`define PMCC_SLOW_SRC_XTAL      2'h1
`define PMCC_SLOW_SRC_EXT       2'h2
`define PMCC_WDOG_RESET         32'h0000_0000
`endif

// *** rtl/pmcc_pkg.sv ***
// Purpose: types for the power mode and clock controller
// Assumes: nothing
// Notes:   mode codes are left to the tool
`default_nettype none
package pmcc_pkg;
    typedef enum logic [2:0] {
        PMCC_ACTIVE,
        PMCC_IDLE,
        PMCC_STANDBY,
        PMCC_SHUTDOWN
    } pmcc_mode_e;
    typedef logic [1:0] pmcc_cause_t;
    typedef logic [1:0] pmcc_slow_src_t;
endpackage
`default_nettype wire

// *** rtl/pmcc_divider.sv ***
// Purpose: one-cycle enable pulses at a divided rate
// Assumes: HALF is at least one
// Notes:   pulse marks each half period of the derived clock
`default_nettype none
module pmcc_divider #(
    parameter int unsigned HALF = 1
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic run_i,
    output var  logic tick_o
);
    localparam int unsigned W = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [W-1:0] LAST = W'(HALF - 1);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_tick;

    // wrap counter, cleared while stopped so the phase restarts cleanly
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (!run_i) begin
            next_count = '0;
        end else if (count == LAST) begin
            next_count = '0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else begin
            count  <= next_count;
            tick_o <= next_tick;
        end
    end
endmodule
`default_nettype wire

// *** rtl/pmcc_core.sv ***
// What this block does
// - active mode runs cpu, peripherals, any clock
// - idle gates cpu and memory, peripherals clocked
// - any interrupt returns idle to active
// - standby powers and clocks always-on domain only
// - standby wakes on pin, timer, sensor event
// - retained peripheral settings survive standby
// - standby wake resumes without reset
// - pins latched on standby entry until wake
// - shutdown powers everything off, pins latched
// - wake pin level change ends shutdown
// - shutdown wake restarts through reset
// - reset cause tells wake pin, reset pin, power-on
// - shutdown keeps only pin latch and flash
// - main clock 48 MHz from rc or crystal
// - medium clock 2 MHz from medium rc only
// - medium clock feeds sensor and power logic
// - slow clock from rc, crystal or pin
// - slow clock drives timer; radio resync marks standby entry and exit
// - slow clock out only from crystal or rc
// - watchdog pauses in standby, resumes after
//
// Purpose: power mode sequencing and system clock selection
// Assumes: all inputs synchronous to CLK_I; requests are pulses
// Notes:   shutdown state is modelled in the always-on latch bank, which
//          this block stands for; a cold reset clears the cause to power-on
`default_nettype none
`include "pmcc_params.svh"
module pmcc_core
    import pmcc_pkg::*;
(
    input  wire  logic                         CLK_I,
    input  wire  logic                         RST_B_I,
    input  wire  logic                         PIN_RESET_I,
    input  wire  logic                         REQ_IDLE_I,
    input  wire  logic                         REQ_STANDBY_I,
    input  wire  logic                         REQ_SHUTDOWN_I,
    input  wire  logic                         IRQ_I,
    input  wire  logic                         WAKE_PIN_EVT_I,
    input  wire  logic                         RTC_EVT_I,
    input  wire  logic                         SENSOR_EVT_I,
    input  wire  logic [`PMCC_PIN_COUNT-1:0]   GPIO_IN_I,
    input  wire  logic [`PMCC_PIN_COUNT-1:0]   SHUTDOWN_WAKE_EN_I,
    input  wire  logic                         MAIN_SRC_XTAL_I,
    input  wire  logic                         FAST_XTAL_READY_I,
    input  wire  pmcc_pkg::pmcc_slow_src_t     SLOW_SRC_I,
    input  wire  logic                         SLOW_EXT_CLK_I,
    input  wire  logic                         SLOW_OUT_EN_I,
    input  wire  logic                         RADIO_REQ_I,
    input  wire  logic                         WDOG_EN_I,
    output var   pmcc_pkg::pmcc_mode_e         MODE_O,
    output var   logic                         CPU_CLK_EN_O,
    output var   logic                         PERIPH_CLK_EN_O,
    output var   logic                         PERIPH_PWR_O,
    output var   logic                         AON_PWR_O,
    output var   logic                         RETENTION_O,
    output var   logic                         PIN_LATCH_O,
    output var   logic [`PMCC_PIN_COUNT-1:0]   PIN_HOLD_O,
    output var   logic                         SYS_RESET_O,
    output var   pmcc_pkg::pmcc_cause_t        RESET_CAUSE_O,
    output var   logic                         MAIN_CLK_XTAL_O,
    output var   logic                         RADIO_EN_O,
    output var   logic                         MEDIUM_CLK_O,
    output var   logic                         SLOW_CLK_O,
    output var   logic                         SLOW_PIN_O,
    output var   logic                         SLOW_PIN_OE_O,
    output var   logic                         RTC_TICK_O,
    output var   logic                         RADIO_RESYNC_O,
    output var   logic [31:0]                  WDOG_COUNT_O
);
    import pmcc_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    // mode lets the cpu clock run
    function automatic logic cpu_runs(input pmcc_mode_e m);
        cpu_runs = (m == PMCC_ACTIVE);
    endfunction

    // peripherals powered and clocked in active and idle only
    function automatic logic periph_on(input pmcc_mode_e m);
        periph_on = (m == PMCC_ACTIVE) || (m == PMCC_IDLE);
    endfunction

    // ************************************************************
    // clock dividers
    // ************************************************************
    logic medium_tick;
    logic slow_tick;
    logic div_run;
    assign div_run = (MODE_O != PMCC_SHUTDOWN);

    pmcc_divider #(.HALF(`PMCC_MEDIUM_HALF_CYCLES)) u_medium_div (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .run_i   (div_run),
        .tick_o  (medium_tick)
    );

    // rc and crystal slow sources are both stood in by the divider
    pmcc_divider #(.HALF(`PMCC_SLOW_HALF_CYCLES)) u_slow_div (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .run_i   (div_run),
        .tick_o  (slow_tick)
    );

    // ************************************************************
    // power mode sequencer
    // ************************************************************
    pmcc_mode_e                 next_mode;
    logic                       next_reset;
    pmcc_cause_t                next_cause;
    logic [`PMCC_PIN_COUNT-1:0] next_hold;
    logic                       next_latch;
    logic [`PMCC_PIN_COUNT-1:0] pin_change;
    logic                       sd_wake;
    logic                       sb_wake;

    // shutdown wake watches the held value against the live pin level
    assign pin_change = (GPIO_IN_I ^ PIN_HOLD_O) & SHUTDOWN_WAKE_EN_I;
    assign sd_wake    = |pin_change;
    assign sb_wake    = WAKE_PIN_EVT_I | RTC_EVT_I | SENSOR_EVT_I;

    // reset pin outranks everything, then wake, then software requests
    always_comb begin
        next_mode  = MODE_O;
        next_reset = 1'b0;
        next_cause = RESET_CAUSE_O;
        next_hold  = PIN_HOLD_O;
        next_latch = PIN_LATCH_O;
        if (PIN_RESET_I) begin
            next_mode  = PMCC_ACTIVE;
            next_reset = 1'b1;
            next_cause = `PMCC_CAUSE_PIN_RESET;
            next_latch = 1'b0;
        end else begin
            case (MODE_O)
                PMCC_ACTIVE: begin
                    // only software moves the mode out of active
                    if (REQ_SHUTDOWN_I) begin
                        next_mode  = PMCC_SHUTDOWN;
                        next_hold  = GPIO_IN_I;
                        next_latch = 1'b1;
                    end else if (REQ_STANDBY_I) begin
                        next_mode  = PMCC_STANDBY;
                        next_hold  = GPIO_IN_I;
                        next_latch = 1'b1;
                    end else if (REQ_IDLE_I) begin
                        next_mode = PMCC_IDLE;
                    end
                end
                PMCC_IDLE: begin
                    if (IRQ_I) begin
                        next_mode = PMCC_ACTIVE;
                    end
                end
                PMCC_STANDBY: begin
                    // interrupts alone are ignored here
                    if (sb_wake) begin
                        next_mode  = PMCC_ACTIVE;
                        next_latch = 1'b0;
                    end
                end
                PMCC_SHUTDOWN: begin
                    if (sd_wake) begin
                        next_mode  = PMCC_ACTIVE;
                        next_reset = 1'b1;
                        next_cause = `PMCC_CAUSE_WAKE_PIN;
                        next_latch = 1'b0;
                    end
                end
                default: begin
                    next_mode = PMCC_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            MODE_O        <= PMCC_ACTIVE;
            SYS_RESET_O   <= 1'b1;
            RESET_CAUSE_O <= `PMCC_CAUSE_POR;
            PIN_HOLD_O    <= '0;
            PIN_LATCH_O   <= 1'b0;
        end else begin
            MODE_O        <= next_mode;
            SYS_RESET_O   <= next_reset;
            RESET_CAUSE_O <= next_cause;
            PIN_HOLD_O    <= next_hold;
            PIN_LATCH_O   <= next_latch;
        end
    end

    // ************************************************************
    // domain enables
    // ************************************************************
    logic next_cpu_en;
    logic next_periph_en;
    logic next_aon;
    logic next_ret;

    // enables follow the registered mode; one cycle behind it
    always_comb begin
        next_cpu_en    = cpu_runs(MODE_O) && !SYS_RESET_O;
        next_periph_en = periph_on(MODE_O);
        next_aon       = (MODE_O != PMCC_SHUTDOWN);
        next_ret       = (MODE_O == PMCC_STANDBY);
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            CPU_CLK_EN_O    <= 1'b0;
            PERIPH_CLK_EN_O <= 1'b0;
            PERIPH_PWR_O    <= 1'b0;
            AON_PWR_O       <= 1'b1;
            RETENTION_O     <= 1'b0;
        end else begin
            CPU_CLK_EN_O    <= next_cpu_en;
            PERIPH_CLK_EN_O <= next_periph_en;
            PERIPH_PWR_O    <= next_periph_en;
            AON_PWR_O       <= next_aon;
            RETENTION_O     <= next_ret;
        end
    end

    // ************************************************************
    // clock selection and outputs
    // ************************************************************
    logic next_xtal;
    logic next_radio;
    logic next_medium;
    logic next_slow;
    logic next_slow_pin;
    logic next_slow_oe;
    logic next_rtc;
    logic next_resync;
    logic slow_int;
    logic slow_prev;

    // internal slow phase toggles on each divider tick
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            slow_int  <= 1'b0;
            slow_prev <= 1'b0;
        end else begin
            slow_int  <= slow_int ^ slow_tick;
            slow_prev <= SLOW_CLK_O;
        end
    end

    always_comb begin
        // crystal only when asked and settled, else the rc keeps running
        next_xtal  = MAIN_SRC_XTAL_I && FAST_XTAL_READY_I;
        // radio refused on the rc source; software must switch first
        next_radio = RADIO_REQ_I && MAIN_CLK_XTAL_O && periph_on(MODE_O);
        // medium clock has a single source, no select exists
        next_medium = MEDIUM_CLK_O ^ medium_tick;
        if (MODE_O == PMCC_SHUTDOWN) begin
            next_medium = 1'b0;
        end
        case (SLOW_SRC_I)
            `PMCC_SLOW_SRC_EXT: next_slow = SLOW_EXT_CLK_I;
            default:            next_slow = slow_int;
        endcase
        if (MODE_O == PMCC_SHUTDOWN) begin
            next_slow = 1'b0;
        end
        // an external slow clock is never echoed back out
        next_slow_oe  = SLOW_OUT_EN_I && (SLOW_SRC_I != `PMCC_SLOW_SRC_EXT)
                        && (MODE_O != PMCC_SHUTDOWN);
        next_slow_pin = next_slow_oe && SLOW_CLK_O;
        next_rtc      = SLOW_CLK_O && !slow_prev;
        next_resync   = ((MODE_O == PMCC_ACTIVE) && (next_mode == PMCC_STANDBY))
                        || ((MODE_O == PMCC_STANDBY) && (next_mode == PMCC_ACTIVE));
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            MAIN_CLK_XTAL_O <= 1'b0;
            RADIO_EN_O      <= 1'b0;
            MEDIUM_CLK_O    <= 1'b0;
            SLOW_CLK_O      <= 1'b0;
            SLOW_PIN_O      <= 1'b0;
            SLOW_PIN_OE_O   <= 1'b0;
            RTC_TICK_O      <= 1'b0;
            RADIO_RESYNC_O  <= 1'b0;
        end else begin
            MAIN_CLK_XTAL_O <= next_xtal;
            RADIO_EN_O      <= next_radio;
            MEDIUM_CLK_O    <= next_medium;
            SLOW_CLK_O      <= next_slow;
            SLOW_PIN_O      <= next_slow_pin;
            SLOW_PIN_OE_O   <= next_slow_oe;
            RTC_TICK_O      <= next_rtc;
            RADIO_RESYNC_O  <= next_resync;
        end
    end

    // ************************************************************
    // watchdog counter
    // ************************************************************
    logic [31:0] next_wdog;

    // counts in active and idle, frozen in standby, cleared by reset
    always_comb begin
        next_wdog = WDOG_COUNT_O;
        if (SYS_RESET_O || (MODE_O == PMCC_SHUTDOWN)) begin
            next_wdog = `PMCC_WDOG_RESET;
        end else if (WDOG_EN_I && periph_on(MODE_O)) begin
            next_wdog = WDOG_COUNT_O + 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            WDOG_COUNT_O <= `PMCC_WDOG_RESET;
        end else begin
            WDOG_COUNT_O <= next_wdog;
        end
    end
endmodule
`default_nettype wire

// *** test/pmcc_core_asserts.sv ***
// Purpose: port-level checks of the power mode controller
// Assumes: bound into pmcc_core, one clock domain
// Notes:   enables trail the mode by one edge, so some checks look back
`default_nettype none
`include "pmcc_params.svh"
module pmcc_core_chk
    import pmcc_pkg::*;
(
    input wire logic                     CLK_I,
    input wire logic                     RST_B_I,
    input wire logic                     PIN_RESET_I,
    input wire logic                     REQ_IDLE_I,
    input wire logic                     REQ_STANDBY_I,
    input wire logic                     REQ_SHUTDOWN_I,
    input wire logic                     IRQ_I,
    input wire logic                     WAKE_PIN_EVT_I,
    input wire logic                     RTC_EVT_I,
    input wire logic                     SENSOR_EVT_I,
    input wire logic [`PMCC_PIN_COUNT-1:0] GPIO_IN_I,
    input wire logic [`PMCC_PIN_COUNT-1:0] SHUTDOWN_WAKE_EN_I,
    input wire pmcc_pkg::pmcc_slow_src_t SLOW_SRC_I,
    input wire pmcc_pkg::pmcc_mode_e     MODE_O,
    input wire logic                     CPU_CLK_EN_O,
    input wire logic                     PERIPH_CLK_EN_O,
    input wire logic                     PERIPH_PWR_O,
    input wire logic                     AON_PWR_O,
    input wire logic                     RETENTION_O,
    input wire logic                     PIN_LATCH_O,
    input wire logic [`PMCC_PIN_COUNT-1:0] PIN_HOLD_O,
    input wire logic                     SYS_RESET_O,
    input wire pmcc_pkg::pmcc_cause_t    RESET_CAUSE_O,
    input wire logic                     SLOW_PIN_OE_O,
    input wire logic [31:0]              WDOG_COUNT_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);
    // ****
    // helper terms
    // ****
    // pin reset overrides every mode move, so it is kept out of the causes
    wire logic evt  = WAKE_PIN_EVT_I | RTC_EVT_I | SENSOR_EVT_I;
    wire logic act  = (MODE_O == PMCC_ACTIVE) && !PIN_RESET_I;
    wire logic reqs = REQ_IDLE_I | REQ_STANDBY_I | REQ_SHUTDOWN_I;
    wire logic stby = (MODE_O == PMCC_STANDBY);
    wire logic flip = |((GPIO_IN_I ^ PIN_HOLD_O) & SHUTDOWN_WAKE_EN_I);
    // ****
    // mode and power checks
    // ****
    no_self_exit_a: assert property (act && !reqs |=> MODE_O == PMCC_ACTIVE)
        else $error("active left without request");
    irq_wake_a: assert property (MODE_O == PMCC_IDLE && IRQ_I && !PIN_RESET_I |=> MODE_O == PMCC_ACTIVE)
        else $error("interrupt did not end idle");
    idle_gate_a: assert property (MODE_O == PMCC_IDLE && $past(MODE_O) == PMCC_IDLE
        |-> !CPU_CLK_EN_O && PERIPH_CLK_EN_O) else $error("idle clock gating wrong");
    stby_hold_a: assert property (stby && !evt && !PIN_RESET_I |=> stby)
        else $error("standby left without wake source");
    stby_wake_a: assert property (stby && evt && !PIN_RESET_I
        |=> MODE_O == PMCC_ACTIVE && !SYS_RESET_O) else $error("standby wake wrong");
    pin_latch_a: assert property (act && REQ_STANDBY_I && !REQ_SHUTDOWN_I
        |=> stby && PIN_LATCH_O && PIN_HOLD_O == $past(GPIO_IN_I)) else $error("pins not latched");
    stby_power_a: assert property (stby && $past(stby)
        |-> AON_PWR_O && !PERIPH_PWR_O && !CPU_CLK_EN_O && RETENTION_O) else $error("standby power wrong");
    wdog_pause_a: assert property (stby && $past(stby) |-> $stable(WDOG_COUNT_O))
        else $error("watchdog moved in standby");
    sd_wake_a: assert property (MODE_O == PMCC_SHUTDOWN && flip && !PIN_RESET_I
        |=> MODE_O == PMCC_ACTIVE && SYS_RESET_O && RESET_CAUSE_O == `PMCC_CAUSE_WAKE_PIN)
        else $error("shutdown wake wrong");
    pin_reset_a: assert property (PIN_RESET_I |=> SYS_RESET_O && RESET_CAUSE_O == `PMCC_CAUSE_PIN_RESET)
        else $error("reset pin cause wrong");
    slow_out_a: assert property ($past(SLOW_SRC_I) == `PMCC_SLOW_SRC_EXT
        && $past(SLOW_SRC_I, 2) == `PMCC_SLOW_SRC_EXT |-> !SLOW_PIN_OE_O) else $error("slow out with pin source");
    cover property (MODE_O == PMCC_IDLE ##1 MODE_O == PMCC_ACTIVE);
    cover property (stby ##1 MODE_O == PMCC_ACTIVE);
    cover property (MODE_O == PMCC_SHUTDOWN ##1 SYS_RESET_O);
endmodule
bind pmcc_core pmcc_core_chk chk (.*);
`default_nettype wire

// *** test/pmcc_wake_model.sv ***
// Purpose: wake sources and external slow clock beside the controller
// Assumes: runs on the bench clock
// Notes:   one wake pulse per request, after a chosen delay
`default_nettype none
module pmcc_wake_model (
    input  wire logic       clk_i,
    input  wire logic       fire_i,
    input  wire logic [1:0] sel_i,
    input  wire logic [7:0] wait_i,
    output var  logic       wake_pin_o,
    output var  logic       rtc_o,
    output var  logic       sensor_o,
    output var  logic       ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       armed = 1'b0;
    logic [1:0] sel   = 2'h0;
    logic [7:0] cnt   = 8'h00;
    logic [2:0] div   = 3'h0;
    initial {wake_pin_o, rtc_o, sensor_o, ext_clk_o} = 4'h0;
    // ****
    // event timing
    // ****
    // a zero delay still costs a cycle, as a synchroniser on the far side would
    always @(posedge clk_i) begin
        {wake_pin_o, rtc_o, sensor_o} <= 3'h0;
        div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
        if (div == 3'h4)
            ext_clk_o <= ~ext_clk_o; // free-running pin clock
        if (fire_i) begin
            armed <= 1'b1;
            sel <= sel_i;
            cnt <= wait_i;
        end else if (armed && cnt != 8'h00)
            cnt <= cnt - 8'h01;
        else if (armed) begin
            armed <= 1'b0;
            wake_pin_o <= (sel == 2'h0);
            rtc_o <= (sel == 2'h1);
            sensor_o <= (sel == 2'h2);
        end
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the power mode controller
// Assumes: 250 MHz clock, seeded random stimulus
// Notes:   expectations come from bench functions and constants
`default_nettype none
`include "pmcc_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmcc_pkg::*;
    // ****
    // signals and instances
    // ****
    logic clk = 1'b0, rst_b = 1'b0, pin_rst = 1'b0, rq_idle = 1'b0, rq_stby = 1'b0, rq_sd = 1'b0, irq = 1'b0;
    logic xsel = 1'b0, xrdy = 1'b0, out_en = 1'b0, radio = 1'b0, wd_en = 1'b1, fire = 1'b0;
    logic s_ext, wk_pin, rtc_evt, sen_evt;
    logic [7:0] gpio = 8'h00, wk_en = 8'h00, pwait = 8'h00, hold;
    logic [1:0] psel = 2'h0;
    pmcc_slow_src_t slow_src = 2'h0;
    pmcc_mode_e mode;
    pmcc_cause_t cause;
    logic cpu_en, per_en, per_pwr, always_on_domain, retain, latch, sys_rst, mxtal, radio_en, med, sclk, spin, soe, rtc_tk, resync;
    logic [31:0] wdog;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    pmcc_core dut (
        .CLK_I(clk), .RST_B_I(rst_b), .PIN_RESET_I(pin_rst), .REQ_IDLE_I(rq_idle), .REQ_STANDBY_I(rq_stby),
        .REQ_SHUTDOWN_I(rq_sd), .IRQ_I(irq), .WAKE_PIN_EVT_I(wk_pin), .RTC_EVT_I(rtc_evt), .SENSOR_EVT_I(sen_evt),
        .GPIO_IN_I(gpio), .SHUTDOWN_WAKE_EN_I(wk_en), .MAIN_SRC_XTAL_I(xsel), .FAST_XTAL_READY_I(xrdy),
        .SLOW_SRC_I(slow_src), .SLOW_EXT_CLK_I(s_ext), .SLOW_OUT_EN_I(out_en), .RADIO_REQ_I(radio),
        .WDOG_EN_I(wd_en), .MODE_O(mode), .CPU_CLK_EN_O(cpu_en), .PERIPH_CLK_EN_O(per_en), .PERIPH_PWR_O(per_pwr),
        .AON_PWR_O(always_on_domain), .RETENTION_O(retain), .PIN_LATCH_O(latch), .PIN_HOLD_O(hold), .SYS_RESET_O(sys_rst),
        .RESET_CAUSE_O(cause), .MAIN_CLK_XTAL_O(mxtal), .RADIO_EN_O(radio_en), .MEDIUM_CLK_O(med),
        .SLOW_CLK_O(sclk), .SLOW_PIN_O(spin), .SLOW_PIN_OE_O(soe), .RTC_TICK_O(rtc_tk), .RADIO_RESYNC_O(resync),
        .WDOG_COUNT_O(wdog));
    pmcc_wake_model far (.clk_i(clk), .fire_i(fire), .sel_i(psel), .wait_i(pwait), .wake_pin_o(wk_pin),
        .rtc_o(rtc_evt), .sensor_o(sen_evt), .ext_clk_o(s_ext));
    // ****
    // clock, timeout and helpers
    // ****
    always #2 clk = ~clk;
    // ceiling sits well above the longest slow clock measurement
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // cycles between two rising edges of a clock or pulse output
    task automatic gap(ref logic s, output int p);
        int r[2];
        int k;
        logic prev;
        k = 0;
        prev = s;
        while (k < 2) begin
            @(posedge clk);
            #1;
            if (s === 1'b1 && prev !== 1'b1) begin
                r[k] = cycles;
                k++;
            end
            prev = s;
        end
        p = r[1] - r[0];
    endtask
    function automatic logic oe_exp(input pmcc_slow_src_t s);
        return s != `PMCC_SLOW_SRC_EXT;
    endfunction
    function automatic pmcc_mode_e sd_mode(input logic [7:0] h, input logic [7:0] g, input logic [7:0] m);
        return (|((h ^ g) & m)) ? PMCC_ACTIVE : PMCC_SHUTDOWN;
    endfunction
    // ****
    // main sequence
    // ****
    initial begin
        logic [7:0] g, m;
        logic [31:0] w;
        int n, p;
        void'($urandom(32'hf1e9));
        wait_cyc(3);
        #1;
        chk({mode, sys_rst, cause, always_on_domain}, {PMCC_ACTIVE, 1'b1, `PMCC_CAUSE_POR, 1'b1});
        wait_cyc(3);
        rst_b <= 1'b1;
        wait_cyc(2);
        #1;
        chk({mode, sys_rst}, {PMCC_ACTIVE, 1'b0});
        @(posedge clk);
        rq_idle <= 1'b1;
        @(posedge clk);
        rq_idle <= 1'b0;
        #1;
        chk(mode, PMCC_IDLE);
        wait_cyc(1);
        #1;
        chk({cpu_en, per_en}, 2'h1);
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        wait_cyc(1);
        #1;
        chk({mode, cpu_en, per_en}, {PMCC_ACTIVE, 2'h3});
        $display("test idle done");
        for (int k = 0; k < 3; k++) begin
            g = 8'($urandom);
            @(posedge clk);
            gpio <= g;
            rq_stby <= 1'b1;
            @(posedge clk);
            rq_stby <= 1'b0;
            gpio <= ~g;
            irq <= 1'b1;
            #1;
            chk({mode, resync}, {PMCC_STANDBY, 1'b1});
            @(posedge clk);
            irq <= 1'b0;
            psel <= 2'(k);
            pwait <= 8'($urandom_range(60));
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            #1;
            chk({mode, hold, always_on_domain, per_pwr, cpu_en, retain}, {PMCC_STANDBY, g, 4'h9});
            w = wdog;
            n = 0;
            while (mode !== PMCC_ACTIVE && n < 200) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk({mode, sys_rst, wdog}, {PMCC_ACTIVE, 1'b0, w});
            $display("test standby wake %0d done", k);
        end
        m = 8'h01 << $urandom_range(7);
        g = 8'($urandom);
        @(posedge clk);
        gpio <= g;
        wk_en <= m;
        rq_sd <= 1'b1;
        @(posedge clk);
        rq_sd <= 1'b0;
        gpio <= g ^ ~m;
        #1;
        chk({mode, hold, latch}, {PMCC_SHUTDOWN, g, 1'b1});
        @(posedge clk);
        gpio <= g ^ 8'hff;
        #1;
        chk({mode, always_on_domain, per_pwr}, {sd_mode(g, g ^ ~m, m), 2'h0});
        @(posedge clk);
        #1;
        chk({mode, sys_rst, cause, wdog, latch},
            {sd_mode(g, ~g, m), 1'b1, `PMCC_CAUSE_WAKE_PIN, `PMCC_WDOG_RESET, 1'b0});
        @(posedge clk);
        pin_rst <= 1'b1;
        @(posedge clk);
        pin_rst <= 1'b0;
        #1;
        chk({sys_rst, cause}, {1'b1, `PMCC_CAUSE_PIN_RESET});
        $display("test shutdown and reset pin done");
        @(posedge clk);
        xsel <= 1'b1;
        radio <= 1'b1;
        wait_cyc(4);
        #1;
        chk({mxtal, radio_en}, 2'h0);
        @(posedge clk);
        xrdy <= 1'b1;
        wait_cyc(4);
        #1;
        chk({mxtal, radio_en}, 2'h3);
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            slow_src <= 2'(s);
            out_en <= 1'b1;
            wait_cyc(4);
            #1;
            chk(soe, oe_exp(2'(s)));
        end
        // model's pin clock toggles every fifth edge, so ten cycles a period
        gap(sclk, p);
        chk({soe, spin, p}, {2'h0, 32'd10});
        @(posedge clk);
        slow_src <= `PMCC_SLOW_SRC_RC;
        gap(med, p);
        chk(p, 2 * `PMCC_MEDIUM_HALF_CYCLES);
        gap(rtc_tk, p);
        chk(p, 2 * `PMCC_SLOW_HALF_CYCLES);
        chk(spin, 1'b1);
        @(posedge clk);
        wd_en <= 1'b0;
        wait_cyc(2);
        #1;
        w = wdog;
        wait_cyc(3);
        #1;
        chk(wdog, w);
        $display("test clocks done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
